// ### ris_selector.v
// reference input selector: buffer decode, reference choice and hitless phase handling
//
// The address map and register access over Wishbone are this design's own decisions.
`include "ris_consts.vh"
module ris_selector #(
    parameter NREF = 4,
    parameter PW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [3:0] monitor_flag_i,
    input wire [1:0] select_pin_i,
    input wire [3:0] common_rate_ok_i,
    input wire [PW-1:0] phase_error_i,
    output reg [1:0] mux_select_o,
    output reg ref_active_o,
    output reg holdover_o,
    output reg [3:0] single_end_termination_switch_o,
    output reg [3:0] differential_termination_switch_o,
    output reg [3:0] bias_switch_o,
    output reg [3:0] capacitor_bypass_switch_o,
    output reg [3:0] diff_amp_detect_o,
    output reg [PW-1:0] phase_correction_o
);
    reg [31:0] ctrl_r, prio_r, buf01_r, buf23_r, slew_r, qual_r;
    reg [1:0] pin_s1_r, pin_s2_r;
    reg [3:0] flag_s1_r, flag_s2_r;
    reg [15:0] qcnt_r [0:3];
    reg [3:0] valid_r;
    reg [1:0] state_r;
    reg [1:0] cur_r;
    reg [PW-1:0] buildout_r;
    reg [15:0] stimer_r;
    reg slewing_r;
    reg [PW-1:0] offset_r;

    wire [1:0] mode = ctrl_r[`RIS_CTRL_MODE_LSB +: 2];
    wire [1:0] man_choice = ctrl_r[`RIS_CTRL_PINSEL_BIT] ? pin_s2_r :
                            ctrl_r[`RIS_CTRL_MAN_LSB +: 2];
    wire cancel_en = ctrl_r[`RIS_CTRL_CANCEL_BIT];
    wire phase_slew_enable = ctrl_r[`RIS_CTRL_SLEW_BIT];
    wire hist_valid = ctrl_r[`RIS_CTRL_HIST_BIT];
    wire [PW-1:0] phase_slew_step_limit = slew_r[PW-1:0];
    wire [15:0] phase_slew_step_timer = slew_r[31:16];

    // best valid input; less-or-equal in a downward scan keeps the lowest index on ties
    function [2:0] best_pick;
        input [3:0] v;
        input [15:0] pr;
        integer k;
        reg [3:0] bp;
        begin
            best_pick = 3'b000;
            bp = 4'hF;
            for (k = 3; k >= 0; k = k - 1) begin
                if (v[k] && pr[4*k +: 4] <= bp) begin
                    bp = pr[4*k +: 4];
                    best_pick = {1'b1, k[1:0]};
                end
            end
        end
    endfunction

    // buffer kind plus coupling to the four switch settings {s1,s2,s3,s4}
    function [3:0] decode_buf;
        input [7:0] f;
        reg [3:0] kind;
        begin
            kind = f[3:0];
            decode_buf = 4'h0;
            if (f[4]) begin
                if (kind == `RIS_KIND_CMOS)
                    decode_buf = 4'h1;
                else if (kind == `RIS_KIND_CMOS50)
                    decode_buf = 4'h9;
            end else begin
                case (kind)
                    `RIS_KIND_DIFF_AC: decode_buf = 4'h2;
                    `RIS_KIND_DIFF_TERM: decode_buf = 4'h4;
                    `RIS_KIND_DIFF_TERM_AC: decode_buf = 4'h6;
                    `RIS_KIND_SE50: decode_buf = 4'h8;
                    `RIS_KIND_SE50_AC: decode_buf = 4'hA;
                    default: decode_buf = 4'h0;
                endcase
            end
        end
    endfunction

    function is_cmos;
        input [7:0] f;
        begin
            is_cmos = (f[3:0] == `RIS_KIND_CMOS) || (f[3:0] == `RIS_KIND_CMOS50);
        end
    endfunction

    // amplitude detector is on while the bypass switch is open; CMOS inputs never use it
    function amp_on;
        input [7:0] f;
        reg [3:0] sw;
        begin
            sw = decode_buf(f);
            amp_on = !sw[0] && !is_cmos(f);
        end
    endfunction

    // register bus, one-cycle ack then a gap
    // the gap keeps a strobe that is still held at the ack edge from being taken twice
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [3:0] wb_idx = wb_adr_i[5:2];

    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (s[b])
                    merge[8*b +: 8] = d[8*b +: 8];
        end
    endfunction

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `RIS_CTRL_RST;
            prio_r <= `RIS_PRIO_RST;
            buf01_r <= 32'h0000_0000;
            buf23_r <= 32'h0000_0000;
            slew_r <= `RIS_SLEW_RST;
            qual_r <= `RIS_QUAL_RST;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && wb_we_i) begin
                if (wb_idx == `RIS_ADR_CTRL)
                    ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
                else if (wb_idx == `RIS_ADR_PRIO)
                    prio_r <= merge(prio_r, wb_dat_i, wb_sel_i);
                else if (wb_idx == `RIS_ADR_BUF01)
                    buf01_r <= merge(buf01_r, wb_dat_i, wb_sel_i);
                else if (wb_idx == `RIS_ADR_BUF23)
                    buf23_r <= merge(buf23_r, wb_dat_i, wb_sel_i);
                else if (wb_idx == `RIS_ADR_SLEW)
                    slew_r <= merge(slew_r, wb_dat_i, wb_sel_i);
                else if (wb_idx == `RIS_ADR_QUAL)
                    qual_r <= merge(qual_r, wb_dat_i, wb_sel_i);
            end
            if (wb_req && !wb_we_i) begin
                if (wb_idx == `RIS_ADR_CTRL)
                    wb_dat_o <= ctrl_r;
                else if (wb_idx == `RIS_ADR_PRIO)
                    wb_dat_o <= prio_r;
                else if (wb_idx == `RIS_ADR_BUF01)
                    wb_dat_o <= buf01_r;
                else if (wb_idx == `RIS_ADR_BUF23)
                    wb_dat_o <= buf23_r;
                else if (wb_idx == `RIS_ADR_SLEW)
                    wb_dat_o <= slew_r;
                else if (wb_idx == `RIS_ADR_QUAL)
                    wb_dat_o <= qual_r;
                else if (wb_idx == `RIS_ADR_PHASE)
                    wb_dat_o <= {{(32-PW){1'b0}}, offset_r};
                else if (wb_idx == `RIS_ADR_STATUS)
                    wb_dat_o <= {22'h0, slewing_r, valid_r, state_r, cur_r, 1'b0};
                else if (wb_idx == `RIS_ADR_OFFSET)
                    wb_dat_o <= {{(32-PW){1'b0}}, buildout_r};
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // pin and monitor synchronisers
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            flag_s1_r <= 4'hF;
            flag_s2_r <= 4'hF;
        end else begin
            pin_s1_r <= select_pin_i;
            pin_s2_r <= pin_s1_r;
            flag_s1_r <= monitor_flag_i;
            flag_s2_r <= flag_s1_r;
        end
    end

    // qualification timers; a flag restarts the wait
    integer q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (q = 0; q < NREF; q = q + 1) begin
                qcnt_r[q] <= 16'h0000;
            end
            valid_r <= 4'h0;
        end else begin
            for (q = 0; q < NREF; q = q + 1) begin
                if (flag_s2_r[q]) begin
                    qcnt_r[q] <= 16'h0000;
                    valid_r[q] <= 1'b0;
                end else if (qcnt_r[q] >= qual_r[15:0]) begin
                    valid_r[q] <= 1'b1;
                end else begin
                    qcnt_r[q] <= qcnt_r[q] + 16'h0001;
                end
            end
        end
    end

    // an input only competes if its predivided rate matches the loop comparison rate
    wire [3:0] usable = valid_r & common_rate_ok_i;
    wire [2:0] best = best_pick(usable, prio_r[15:0]);

    reg [1:0] state_nxt;
    reg [1:0] cur_nxt;
    always @* begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        case (mode)
            `RIS_MODE_AUTO_REV: begin
                if (best[2]) begin
                    cur_nxt = best[1:0];
                    state_nxt = `RIS_ST_TRACK;
                end
            end
            `RIS_MODE_AUTO_NREV: begin
                if (state_r == `RIS_ST_TRACK && usable[cur_r]) begin
                    cur_nxt = cur_r;
                end else if (best[2]) begin
                    cur_nxt = best[1:0];
                    state_nxt = `RIS_ST_TRACK;
                end
            end
            `RIS_MODE_MAN_FALL: begin
                if (usable[man_choice]) begin
                    cur_nxt = man_choice;
                    state_nxt = `RIS_ST_TRACK;
                end else if (best[2]) begin
                    cur_nxt = best[1:0];
                    state_nxt = `RIS_ST_TRACK;
                end
            end
            default: begin
                if (usable[man_choice]) begin
                    cur_nxt = man_choice;
                    state_nxt = `RIS_ST_TRACK;
                end else begin
                    // an unusable manual choice drops out of tracking, other inputs are not tried
                    state_nxt = `RIS_ST_FREERUN;
                end
            end
        endcase
        if (!(state_nxt == `RIS_ST_TRACK && usable[cur_nxt]))
            state_nxt = hist_valid ? `RIS_ST_HOLD : `RIS_ST_FREERUN;
    end

    wire switching = (state_nxt == `RIS_ST_TRACK) &&
                     (state_r == `RIS_ST_TRACK) && (cur_nxt != cur_r);
    wire acquiring = (state_nxt == `RIS_ST_TRACK) && (state_r != `RIS_ST_TRACK);
    // locked pairs share the common rate so the measured offset is a fixed phase
    wire freq_locked = common_rate_ok_i[cur_r] && common_rate_ok_i[cur_nxt];

    wire [PW-1:0] neg_lim = {PW{1'b0}} - phase_slew_step_limit;
    wire signed [PW-1:0] bo_s = buildout_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= `RIS_ST_FREERUN;
            cur_r <= 2'h0;
            buildout_r <= {PW{1'b0}};
            stimer_r <= 16'h0000;
            slewing_r <= 1'b0;
            offset_r <= {PW{1'b0}};
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            // last offset measured at a switch or on acquisition, kept for software even when nothing is built out
            if (switching || acquiring)
                offset_r <= phase_error_i;
            if (switching && cancel_en && freq_locked) begin
                buildout_r <= buildout_r + phase_error_i;
                slewing_r <= phase_slew_enable;
                stimer_r <= 16'h0000;
            end else if ((acquiring || (switching && !freq_locked)) && phase_slew_enable) begin
                buildout_r <= phase_error_i;
                slewing_r <= 1'b1;
                stimer_r <= 16'h0000;
            end else if (switching || acquiring) begin
                buildout_r <= {PW{1'b0}};
                slewing_r <= 1'b0;
            end else if (slewing_r && phase_slew_enable) begin
                // steps toward zero from either sign; the last partial step clears the rest
                if (stimer_r >= phase_slew_step_timer) begin
                    stimer_r <= 16'h0000;
                    if (!bo_s[PW-1] && buildout_r > phase_slew_step_limit)
                        buildout_r <= buildout_r - phase_slew_step_limit;
                    else if (bo_s[PW-1] && buildout_r < neg_lim)
                        buildout_r <= buildout_r + phase_slew_step_limit;
                    else begin
                        buildout_r <= {PW{1'b0}};
                        slewing_r <= 1'b0;
                    end
                end else begin
                    stimer_r <= stimer_r + 16'h0001;
                end
            end else if (!phase_slew_enable) begin
                slewing_r <= 1'b0;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mux_select_o <= 2'h0;
            ref_active_o <= 1'b0;
            holdover_o <= 1'b0;
            phase_correction_o <= {PW{1'b0}};
            single_end_termination_switch_o <= 4'h0;
            differential_termination_switch_o <= 4'h0;
            bias_switch_o <= 4'h0;
            capacitor_bypass_switch_o <= 4'h0;
            diff_amp_detect_o <= 4'h0;
        end else begin
            mux_select_o <= cur_r;
            ref_active_o <= (state_r == `RIS_ST_TRACK);
            holdover_o <= (state_r == `RIS_ST_HOLD);
            phase_correction_o <= buildout_r;
            {single_end_termination_switch_o[0], differential_termination_switch_o[0],
             bias_switch_o[0], capacitor_bypass_switch_o[0]} <= decode_buf(buf01_r[7:0]);
            {single_end_termination_switch_o[1], differential_termination_switch_o[1],
             bias_switch_o[1], capacitor_bypass_switch_o[1]} <= decode_buf(buf01_r[15:8]);
            {single_end_termination_switch_o[2], differential_termination_switch_o[2],
             bias_switch_o[2], capacitor_bypass_switch_o[2]} <= decode_buf(buf23_r[7:0]);
            {single_end_termination_switch_o[3], differential_termination_switch_o[3],
             bias_switch_o[3], capacitor_bypass_switch_o[3]} <= decode_buf(buf23_r[15:8]);
            diff_amp_detect_o[0] <= amp_on(buf01_r[7:0]);
            diff_amp_detect_o[1] <= amp_on(buf01_r[15:8]);
            diff_amp_detect_o[2] <= amp_on(buf23_r[7:0]);
            diff_amp_detect_o[3] <= amp_on(buf23_r[15:8]);
        end
    end
endmodule

// ### ris_consts.vh
// constants for the reference input selector
`ifndef RIS_CONSTS_VH
`define RIS_CONSTS_VH
`define RIS_ADR_CTRL 4'h0
`define RIS_ADR_PRIO 4'h1
`define RIS_ADR_BUF01 4'h2
`define RIS_ADR_BUF23 4'h3
`define RIS_ADR_SLEW 4'h4
`define RIS_ADR_QUAL 4'h5
`define RIS_ADR_PHASE 4'h6
`define RIS_ADR_STATUS 4'h7
`define RIS_ADR_OFFSET 4'h8
`define RIS_CTRL_RST 32'h0000_0000
`define RIS_PRIO_RST 32'h0000_3210
`define RIS_SLEW_RST 32'h0010_0100
`define RIS_QUAL_RST 32'h0000_0100
`define RIS_MODE_AUTO_REV 2'h0
`define RIS_MODE_AUTO_NREV 2'h1
`define RIS_MODE_MAN_FALL 2'h2
`define RIS_MODE_MAN_HOLD 2'h3
`define RIS_CTRL_MODE_LSB 0
`define RIS_CTRL_MAN_LSB 2
`define RIS_CTRL_PINSEL_BIT 4
`define RIS_CTRL_CANCEL_BIT 5
`define RIS_CTRL_SLEW_BIT 6
`define RIS_CTRL_HIST_BIT 7
`define RIS_KIND_DIFF_DC 4'h0
`define RIS_KIND_DIFF_AC 4'h1
`define RIS_KIND_DIFF_TERM 4'h2
`define RIS_KIND_DIFF_TERM_AC 4'h3
`define RIS_KIND_SE50 4'h4
`define RIS_KIND_SE50_AC 4'h5
`define RIS_KIND_CMOS 4'h8
`define RIS_KIND_CMOS50 4'hC
`define RIS_ST_FREERUN 2'h0
`define RIS_ST_TRACK 2'h1
`define RIS_ST_HOLD 2'h2
`endif

// ### ris_selector_checker.sv
// concurrent checks on the reference input selector ports
module ris_selector_checker #(
    parameter NREF = 4,
    parameter PW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [3:0] monitor_flag_i,
    input wire [1:0] mux_select_o,
    input wire ref_active_o,
    input wire holdover_o,
    input wire [3:0] single_end_termination_switch_o,
    input wire [3:0] differential_termination_switch_o,
    input wire [3:0] bias_switch_o,
    input wire [3:0] capacitor_bypass_switch_o,
    input wire [3:0] diff_amp_detect_o,
    input wire [PW-1:0] phase_correction_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    term_excl_a:
        assert property ((single_end_termination_switch_o & differential_termination_switch_o)
            == 4'h0) else $error("both terminations closed on one input");
    bypass_bias_a:
        assert property ((capacitor_bypass_switch_o & (bias_switch_o
            | differential_termination_switch_o)) == 4'h0) else $error("bypass with bias");
    bypass_amp_a:
        assert property ((capacitor_bypass_switch_o & diff_amp_detect_o) == 4'h0)
        else $error("amplitude detector on with bypass closed");
    hold_excl_a:
        assert property (!(holdover_o && ref_active_o)) else $error("holdover while tracking");
    hold_exit_a:
        assert property ($fell(holdover_o) |-> ref_active_o) else $error("holdover left idle");
    qual_clean_a:
        assert property ($rose(ref_active_o) |-> ($past(monitor_flag_i, 5)
            & (4'h1 << mux_select_o)) == 4'h0) else $error("flagged input taken");
    flag_drop_a:
        assert property ((ref_active_o && monitor_flag_i[mux_select_o]) [*8] |-> 1'h0)
        else $error("flagged input kept as active reference");
    reset_out_a: assert property (disable iff (1'h0) rst_i |=> !ref_active_o && !holdover_o
        && capacitor_bypass_switch_o == 4'h0 && phase_correction_o == '0)
        else $error("outputs not cleared by reset");
endmodule
bind ris_selector ris_selector_checker #(.NREF(NREF), .PW(PW)) ris_selector_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .monitor_flag_i(monitor_flag_i), .mux_select_o(mux_select_o),
    .ref_active_o(ref_active_o), .holdover_o(holdover_o),
    .single_end_termination_switch_o(single_end_termination_switch_o),
    .differential_termination_switch_o(differential_termination_switch_o),
    .bias_switch_o(bias_switch_o), .capacitor_bypass_switch_o(capacitor_bypass_switch_o),
    .diff_amp_detect_o(diff_amp_detect_o), .phase_correction_o(phase_correction_o));

// ### ris_ref_model.sv
// far-side model: reference sources with their monitors and the host selection pins
module ris_ref_model (
    input wire clk_i,
    input wire [3:0] bad_i,
    input wire [1:0] pin_i,
    input wire [3:0] rate_i,
    input wire [15:0] phase_i,
    output logic [3:0] monitor_flag_o = 4'hF,
    output logic [1:0] select_pin_o = 2'h0,
    output logic [3:0] common_rate_ok_o = 4'hF,
    output logic [15:0] phase_error_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 100ps;
    // the bench holds the measured phase between switches so the build-out is predictable
    always @(posedge clk_i) begin
        monitor_flag_o <= bad_i;
        select_pin_o <= pin_i;
        common_rate_ok_o <= rate_i;
        phase_error_o <= phase_i;
    end
endmodule

// ### testbench.sv
// self-checking bench for the reference input selector
`include "ris_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {bit k; logic [39:0] v;} ris_note_t;
    ris_note_t q[$];
    ris_note_t note;
    logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic snap = 1'h0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0, bad = 4'hF, rate = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [1:0] pins = 2'h0;
    logic [19:0] exp_buf = 20'h0;
    logic [15:0] ph = 16'h0, exp_ph = 16'h0;
    logic [39:0] seen;
    logic [4:0] tbl [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h18, 5'h1C};
    int errors = 0, n_compared = 0, cycles = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, ref_active_o, holdover_o;
    wire [1:0] mux_select_o, select_pin_i;
    wire [3:0] monitor_flag_i, common_rate_ok_i, se, dt, bias, byp, amp;
    wire [15:0] phase_error_i, phase_correction_o;
    // the mux index means nothing outside tracking, so it is masked there
    wire [39:0] obs = {se, dt, bias, byp, amp, ref_active_o ? mux_select_o : 2'h0,
        ref_active_o, holdover_o, phase_correction_o};
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    ris_ref_model ris_ref_model_i (.clk_i(clk_i), .bad_i(bad), .pin_i(pins), .rate_i(rate),
        .phase_i(ph),
        .monitor_flag_o(monitor_flag_i), .select_pin_o(select_pin_i),
        .common_rate_ok_o(common_rate_ok_i), .phase_error_o(phase_error_i));
    ris_selector ris_selector_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .monitor_flag_i(monitor_flag_i), .select_pin_i(select_pin_i),
        .common_rate_ok_i(common_rate_ok_i), .phase_error_i(phase_error_i),
        .mux_select_o(mux_select_o), .ref_active_o(ref_active_o), .holdover_o(holdover_o),
        .single_end_termination_switch_o(se), .differential_termination_switch_o(dt),
        .bias_switch_o(bias), .capacitor_bypass_switch_o(byp), .diff_amp_detect_o(amp),
        .phase_correction_o(phase_correction_o));
    task automatic test_done;
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] d,
        input logic [31:0] ex);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= d;
        if (!we)
            q.push_back('{1'b0, {8'h00, ex}});
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1)
            @(posedge clk_i);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        @(posedge clk_i);
    endtask
    // margin covers the two-stage sync plus the five-cycle qualification (count limit 4) we program
    task automatic expect_out(input logic [3:0] s);
        logic [39:0] e;
        int n;
        e = {exp_buf, s, exp_ph};
        n = 0;
        repeat (12) @(posedge clk_i);
        while (obs !== e && n < 100) begin
            n++;
            @(posedge clk_i);
        end
        q.push_back('{1'b1, e});
        snap <= 1'h1;
        @(posedge clk_i);
        snap <= 1'h0;
    endtask
    task automatic step(input logic [3:0] b, input logic [3:0] s);
        bad <= b;
        expect_out(s);
    endtask
    function automatic logic [4:0] dec(input logic [4:0] e);
        logic cm;
        cm = (e[3:0] == 4'h8 || e[3:0] == 4'hC);
        dec[4] = e[4] ? e[3:0] == 4'hC : (e[3:0] == 4'h4 || e[3:0] == 4'h5);
        dec[3] = !e[4] && (e[3:0] == 4'h2 || e[3:0] == 4'h3);
        dec[2] = !e[4] && (e[3:0] == 4'h1 || e[3:0] == 4'h3 || e[3:0] == 4'h5);
        dec[1] = e[4] && cm;
        dec[0] = !cm;
    endfunction
    always @(posedge clk_i) begin
        if ((wb_ack_o === 1'h1 && !wb_we_i) || snap) begin
            n_compared++;
            note = q.pop_front();
            seen = note.k ? obs : {8'h00, wb_dat_o};
            if (seen !== note.v) begin
                errors++;
                $display("CHECK FAILED %s expected %h seen %h", note.k ? "outputs" : "read data",
                    note.v, seen);
            end
        end
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        logic [4:0] e [4];
        logic [4:0] d;
        void'($urandom(81358));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        ph <= 16'($urandom);
        @(posedge clk_i);
        wb(0, `RIS_ADR_CTRL, 0, `RIS_CTRL_RST);
        wb(0, `RIS_ADR_PRIO, 0, `RIS_PRIO_RST);
        wb(0, `RIS_ADR_SLEW, 0, `RIS_SLEW_RST);
        wb(0, `RIS_ADR_QUAL, 0, `RIS_QUAL_RST);
        wb(1, 4'hF, 32'hFFFF_FFFF, 0);
        wb(0, 4'hF, 0, 32'h0);
        wb(1, `RIS_ADR_QUAL, 32'h4, 0);
        for (int r = 0; r < 9; r++) begin
            for (int i = 0; i < 4; i++) begin
                e[i] = tbl[i == 0 ? r : $urandom_range(8)];
                d = dec(e[i]);
                for (int b = 0; b < 5; b++)
                    exp_buf[4 * b + i] = d[b];
            end
            wb(1, `RIS_ADR_BUF01, {19'h0, e[1], 3'h0, e[0]}, 0);
            wb(1, `RIS_ADR_BUF23, {19'h0, e[3], 3'h0, e[2]}, 0);
            expect_out(4'h0);
        end
        wb(1, `RIS_ADR_CTRL, 32'h80, 0);
        step(4'hD, 4'h6);
        step(4'h0, 4'h2);
        wb(1, `RIS_ADR_CTRL, 32'h81, 0);
        step(4'h1, 4'h6);
        step(4'h0, 4'h6);
        step(4'h2, 4'h2);
        wb(1, `RIS_ADR_CTRL, 32'h8E, 0);
        step(4'h0, 4'hE);
        step(4'h8, 4'h2);
        step(4'hF, 4'h1);
        step(4'h7, 4'hE);
        pins <= 2'h2;
        wb(1, `RIS_ADR_CTRL, 32'h93, 0);
        step(4'h0, 4'hA);
        step(4'h4, 4'h1);
        step(4'h0, 4'hA);
        wb(1, `RIS_ADR_CTRL, 32'h13, 0);
        step(4'h4, 4'h0);
        wb(1, `RIS_ADR_CTRL, 32'h80, 0);
        wb(1, `RIS_ADR_PRIO, 32'h1001, 0);
        rate <= 4'hD;
        step(4'h0, 4'hA);
        rate <= 4'hF;
        step(4'h0, 4'h6);
        wb(1, `RIS_ADR_CTRL, 32'hA0, 0);
        exp_ph = ph;
        step(4'h2, 4'hA);
        wb(0, `RIS_ADR_PHASE, 0, {16'h0, exp_ph});
        wb(1, `RIS_ADR_SLEW, 32'hFFFF_1000, 0);
        wb(1, `RIS_ADR_CTRL, 32'hE0, 0);
        step(4'hF, 4'h1);
        ph <= 16'($urandom);
        wb(0, `RIS_ADR_OFFSET, 0, {16'h0, exp_ph});
        exp_ph = ph;
        step(4'h0, 4'h6);
        wb(1, `RIS_ADR_SLEW, 32'h0002_1000, 0);
        exp_ph = 16'h0000;
        expect_out(4'h6);
        @(posedge clk_i);
        test_done();
    end
endmodule
